/* dms_mode_ctrl.sv */
// Mode state machine with lock indication for the line-card clock loop
`timescale 1ns/1ps
module dms_mode_ctrl
   import dms_pkg::*;
#(
   parameter int HOLD_CYC = LOCK_HOLD_CYC,
   parameter int QUAL_CYC = LOCK_QUAL_CYC
)(
   input  wire logic      clk,     // Master clock, 100 MHz
   input  wire logic      rst_b,   // Reset, active low, asynchronous
   input  wire logic      ref_in,  // Reference clock from the network source
   input  dms_mon_s       mon,     // Monitor failure flags and phase window
   output dms_stat_s      stat     // Mode, oscillator source, lock, fail, rate
);

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta_reg;
   logic rst_n;

   // Async assert, two-flop release; pulse width is the far side's duty
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Rate detection

   dms_rate_e rate;
   logic      rate_valid;

   dms_rate_detect u_rate (
      .clk        (clk),
      .rst_n      (rst_n),
      .ref_in     (ref_in),
      .rate       (rate),
      .rate_valid (rate_valid)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Mode state machine

   logic      mon_fail;
   logic      disrupt;
   dms_mode_e mode_reg, mode_next;

   assign mon_fail = mon.single_period_monitor | mon.coarse_freq_monitor;
   // Unknown rate also means no usable reference
   assign disrupt  = mon_fail | ~rate_valid;

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         ST_FREERUN: begin
            if (!disrupt) begin
               mode_next = ST_NORMAL;
            end else begin
               mode_next = ST_FREERUN;
            end
         end
         ST_NORMAL: begin
            if (disrupt) begin
               mode_next = ST_FREERUN;
            end
         end
         default: mode_next = ST_FREERUN;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= ST_FREERUN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Lock qualification and hold-over

   logic [QUAL_W-1:0] qual_reg, qual_next;
   logic [HOLD_W-1:0] hold_reg, hold_next;
   logic              holding_reg, holding_next;
   logic              lock_reg, lock_next;
   logic              fail_reg, fail_next;

   always_comb begin
      qual_next    = '0;
      hold_next    = hold_reg;
      holding_next = holding_reg;
      lock_next    = lock_reg;
      fail_next    = mon_fail;
      if (mode_reg == ST_NORMAL) begin
         holding_next = 1'b0;
         hold_next    = '0;
         if (!mon.phase_in_window) begin
            qual_next = '0;
         end else if (qual_reg == QUAL_W'(QUAL_CYC - 1)) begin
            qual_next = qual_reg;
            // No fresh lock on the edge that leaves Normal
            lock_next = lock_reg | ~disrupt;
         end else begin
            qual_next = qual_reg + QUAL_W'(1);
         end
         if (mode_next == ST_FREERUN && lock_reg) begin
            holding_next = 1'b1;
         end
      end else if (holding_reg) begin
         // Ride through short hits without dropping lock
         if (hold_reg == HOLD_W'(HOLD_CYC - 1)) begin
            holding_next = 1'b0;
            lock_next    = 1'b0;
            hold_next    = '0;
         end else begin
            hold_next = hold_reg + HOLD_W'(1);
         end
      end else begin
         lock_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qual_reg    <= '0;
         hold_reg    <= '0;
         holding_reg <= 1'b0;
         lock_reg    <= 1'b0;
         fail_reg    <= 1'b0;
      end else begin
         qual_reg    <= qual_next;
         hold_reg    <= hold_next;
         holding_reg <= holding_next;
         lock_reg    <= lock_next;
         fail_reg    <= fail_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   always_comb begin
      stat.mode        = mode_reg;
      stat.dco_ref_sel = (mode_reg == ST_NORMAL);
      stat.lock        = lock_reg;
      stat.ref_fail    = fail_reg;
      stat.rate        = rate;
      stat.rate_valid  = rate_valid;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_reset_start;
      @(posedge clk) disable iff (1'b0) $rose(rst_n) |-> mode_reg == ST_FREERUN && !lock_reg;
   endproperty

   reset_freerun_a: assert property (p_reset_start)
      else $error("mode not freerun after reset release");

   freerun_hold_a: assert property (
      mode_reg == ST_FREERUN && disrupt |=> mode_reg == ST_FREERUN)
      else $error("left freerun while reference disrupted");

   normal_entry_a: assert property (
      mode_reg == ST_FREERUN && !disrupt |=> mode_reg == ST_NORMAL)
      else $error("clean reference did not bring normal mode");

   auto_fallback_a: assert property (
      mode_reg == ST_NORMAL && disrupt |=> mode_reg == ST_FREERUN)
      else $error("disruption did not force freerun");

   dco_source_a: assert property (
      stat.dco_ref_sel |-> !$past(disrupt))
      else $error("oscillator steered by a disrupted reference");

   lost_rate_a: assert property (
      $fell(rate_valid) && mode_reg == ST_NORMAL |=> mode_reg == ST_FREERUN)
      else $error("loss of reference rate kept normal mode");

   monitor_fail_a: assert property (
      mon_fail |=> mode_reg == ST_FREERUN)
      else $error("monitor failure did not force freerun");

   ref_fail_out_a: assert property (
      mon_fail |=> stat.ref_fail)
      else $error("reference fail output missed a monitor failure");

   freerun_clears_qual_a: assert property (
      mode_reg == ST_FREERUN |=> qual_reg == '0)
      else $error("lock qualification survives freerun");

   lock_holdover_a: assert property (
      mode_reg == ST_NORMAL && lock_reg && disrupt |=> lock_reg [*8])
      else $error("lock dropped early after leaving normal");

   lock_drop_a: assert property (
      holding_reg && hold_reg == HOLD_W'(HOLD_CYC - 1) && mode_reg == ST_FREERUN |=> !lock_reg)
      else $error("lock not dropped at end of hold time");

   freerun_unlocked_a: assert property (
      mode_reg == ST_FREERUN && !holding_reg |-> !lock_reg)
      else $error("lock high in freerun without hold-over");

   enter_normal_c: cover property (mode_reg == ST_FREERUN ##1 mode_reg == ST_NORMAL);
   lock_gain_c:    cover property ($rose(lock_reg));
   holdover_c:     cover property ($rose(holding_reg) ##[1:20] mode_reg == ST_NORMAL);
   lock_loss_c:    cover property ($fell(lock_reg));

endmodule : dms_mode_ctrl

/* dms_mode_ctrl_tb.sv */
// Self-checking bench for the mode state machine
`timescale 1ns/1ps
module dms_mode_ctrl_tb;
   import dms_pkg::*;
   localparam int HOLD = 50;
   localparam int QUAL = 4;
   localparam logic [13:0] PER [4] = '{14'h30D4, 14'h0031, 14'h000C, 14'h0005};
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ref_in;
   logic        run = 1'b0;
   logic [13:0] period = 14'h0031;
   logic [15:0] seed = 16'h365A;
   dms_mon_s    mon = '0;
   dms_stat_s   stat;
   int          errors = 0;
   int          comparisons = 0;
   int          k;
   int          m;
   int          len;
   always #5 clk = ~clk;
   dms_ref_source src (.clk(clk), .run(run), .period(period), .ref_out(ref_in));
   dms_mode_ctrl #(.HOLD_CYC(HOLD), .QUAL_CYC(QUAL)) dut (
      .clk(clk), .rst_b(rst_b), .ref_in(ref_in), .mon(mon), .stat(stat));
   ////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_f(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_f
   // Nominal rate from the shortest legal period of each band
   function automatic dms_rate_e class_f(logic [13:0] p);
      if (p >= 14'h2F44) return RATE_8K;
      if (p >= 14'h001A) return RATE_2M048;
      if (p >= 14'h0006) return RATE_8M192;
      return RATE_19M44;
   endfunction : class_f
   task automatic step(int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic chk(logic got, logic exp, string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s got %b", $time, what, got);
      end
   endtask : chk
   task automatic chk_mode(dms_mode_e e);
      comparisons++;
      if ({stat.mode, stat.dco_ref_sel} !== {e, e == ST_NORMAL}) begin
         errors++;
         $display("MISMATCH t=%0t mode %b sel %b", $time, stat.mode, stat.dco_ref_sel);
      end
   endtask : chk_mode
   task automatic chk_rate(dms_rate_e e);
      comparisons++;
      if ({stat.rate, stat.rate_valid} !== {e, 1'b1}) begin
         errors++;
         $display("MISMATCH t=%0t rate %b valid %b", $time, stat.rate, stat.rate_valid);
      end
   endtask : chk_rate
   task automatic wait_mode(dms_mode_e e, int n);
      for (int i = 0; i < n && stat.mode !== e; i++) begin
         @(negedge clk);
      end
      chk_mode(e);
   endtask : wait_mode
   task automatic wait_lock();
      for (int i = 0; i < QUAL + 4 && stat.lock !== 1'b1; i++) begin
         @(negedge clk);
      end
   endtask : wait_lock
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////
   initial begin
      // Two 8 kHz periods, one rate timeout and margin
      #600_000;
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      step(2);
      chk_mode(ST_FREERUN);
      chk(stat.lock, 1'b0, "lock in reset");
      @(posedge clk);
      rst_b <= 1'b1;
      step(40);
      chk_mode(ST_FREERUN);
      $display("test reset done");
      @(posedge clk);
      run <= 1'b1;
      mon <= 3'b001;
      for (m = 0; m < 4; m++) begin
         @(posedge clk);
         period <= PER[m];
         for (k = 0; k < 26000 && {stat.rate, stat.rate_valid} !== {class_f(PER[m]), 1'b1}; k++) begin
            @(negedge clk);
         end
         chk_rate(class_f(PER[m]));
         wait_mode(ST_NORMAL, 4);
         wait_lock();
         chk(stat.lock, 1'b1, "lock rise");
      end
      $display("test rates done");
      for (m = 0; m < 2; m++) begin
         seed = lfsr_f(seed);
         len = int'(seed[2:0]) + 1;
         @(posedge clk);
         period <= PER[1 + int'(seed[4:3]) % 3];
         wait_mode(ST_NORMAL, 300);
         wait_lock();
         // Short hit: lock must ride through it
         @(posedge clk);
         mon <= dms_mon_s'({m == 0, m == 1, 1'b1});
         step(2);
         chk_mode(ST_FREERUN);
         chk(stat.ref_fail, 1'b1, "fail flag");
         chk(stat.lock, 1'b1, "lock hold");
         repeat (len) @(posedge clk);
         mon <= 3'b001;
         wait_mode(ST_NORMAL, 6);
         chk(stat.ref_fail, 1'b0, "fail clear");
         chk(stat.lock, 1'b1, "lock kept");
         // Long hit: lock must drop once the hold runs out
         @(posedge clk);
         mon <= dms_mon_s'({m == 0, m == 1, 1'b1});
         step(HOLD + 1);
         chk(stat.lock, 1'b1, "lock late hold");
         step(1);
         chk(stat.lock, 1'b0, "lock drop");
         chk_mode(ST_FREERUN);
         @(posedge clk);
         mon <= 3'b001;
         wait_mode(ST_NORMAL, 6);
      end
      $display("test monitors done");
      @(posedge clk);
      run <= 1'b0;
      wait_mode(ST_FREERUN, 13000);
      chk(stat.rate_valid, 1'b0, "rate lost");
      step(20);
      chk_mode(ST_FREERUN);
      @(posedge clk);
      run <= 1'b1;
      wait_mode(ST_NORMAL, 200);
      $display("test loss done");
      wait_lock();
      @(posedge clk);
      rst_b <= 1'b0;
      #1;
      chk_mode(ST_FREERUN);
      chk(stat.lock, 1'b0, "lock at reset");
      step(RST_MIN_CYC);
      @(posedge clk);
      rst_b <= 1'b1;
      step(3);
      chk_mode(ST_FREERUN);
      chk(stat.lock, 1'b0, "lock after reset");
      wait_mode(ST_NORMAL, 200);
      $display("test reset again done");
      tally_and_finish();
   end
endmodule : dms_mode_ctrl_tb

/* dms_pkg.sv */
// Package for the reference-driven mode state machine of the line-card clock loop
// What this block does
// - Once reset is released the loop starts in Freerun, timed from the local master clock only.
// - In Freerun the loop stays there as long as the monitors report the reference disrupted.
// - In Freerun an undisturbed reference moves the loop into Normal mode.
// - In Normal a disruption seen by the monitors sends the loop back to Freerun with no command.
// - In Normal all output clocks and framing are steered from the reference input.
// - The rate of the reference is found by the block itself, with no configuration input.
// - A single-period or coarse-frequency monitor failure counts as a disruption and forces Freerun.
// - A single-period or coarse-frequency monitor past its threshold drives the reference-fail output high.
// - On leaving a locked Normal state the lock output stays high 0.1 s, then drops if still in Freerun.
// - In Freerun the oscillator runs from the master clock alone.
package dms_pkg;

   localparam int CLK_HZ         = 100_000_000;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int RST_MIN_NS     = 300;
   localparam int RST_MIN_CYC    = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_HOLD_MS   = 100;
   localparam int LOCK_HOLD_CYC  = LOCK_HOLD_MS * (CLK_HZ / 1000);
   localparam int LOCK_QUAL_CYC  = 1000;
   localparam int HOLD_W         = 24;
   localparam int QUAL_W         = 16;

   // Reference period windows, in clock cycles, per nominal rate
   localparam int PER_W          = 14;
   localparam int P19M_MAX       = 7;
   localparam int P8M_MIN        = 6;
   localparam int P8M_MAX        = 18;
   localparam int P2M_MIN        = 26;
   localparam int P2M_MAX        = 72;
   localparam int P8K_MIN        = 12100;
   localparam int P8K_MAX        = 12800;

   typedef enum logic [1:0] {RATE_8K, RATE_2M048, RATE_8M192, RATE_19M44} dms_rate_e;
   typedef enum logic {ST_FREERUN, ST_NORMAL} dms_mode_e;

   typedef struct packed {
      logic single_period_monitor;
      logic coarse_freq_monitor;
      logic phase_in_window;
   } dms_mon_s;

   typedef struct packed {
      dms_mode_e mode;
      logic      dco_ref_sel;
      logic      lock;
      logic      ref_fail;
      dms_rate_e rate;
      logic      rate_valid;
   } dms_stat_s;

endpackage : dms_pkg

/* dms_rate_detect.sv */
// Reference rate detector: measures the reference period in clock cycles
`timescale 1ns/1ps
module dms_rate_detect
   import dms_pkg::*;
(
   input  wire logic      clk,        // Master clock
   input  wire logic      rst_n,      // Synchronised reset, active low
   input  wire logic      ref_in,     // Reference input
   output dms_rate_e      rate,       // Detected nominal rate
   output logic           rate_valid  // Period matches a supported rate
);

   logic              ref_d_reg,   ref_d_next;
   logic [PER_W-1:0]  cnt_reg,     cnt_next;
   dms_rate_e         rate_reg,    rate_next;
   logic              valid_reg,   valid_next;
   logic              edge_seen;

   assign edge_seen = ref_in & ~ref_d_reg;

   always_comb begin
      ref_d_next = ref_in;
      cnt_next   = cnt_reg;
      rate_next  = rate_reg;
      valid_next = valid_reg;
      if (edge_seen) begin
         cnt_next   = PER_W'(1);
         valid_next = 1'b1;
         if (cnt_reg <= PER_W'(P19M_MAX) && cnt_reg < PER_W'(P8M_MIN)) begin
            rate_next = RATE_19M44;
         end else if (cnt_reg >= PER_W'(P8M_MIN) && cnt_reg <= PER_W'(P8M_MAX)) begin
            rate_next = RATE_8M192;
         end else if (cnt_reg >= PER_W'(P2M_MIN) && cnt_reg <= PER_W'(P2M_MAX)) begin
            rate_next = RATE_2M048;
         end else if (cnt_reg >= PER_W'(P8K_MIN) && cnt_reg <= PER_W'(P8K_MAX)) begin
            rate_next = RATE_8K;
         end else begin
            valid_next = 1'b0;
         end
      end else if (cnt_reg > PER_W'(P8K_MAX)) begin
         // Missing edges: no rate can be claimed any more
         valid_next = 1'b0;
      end else begin
         cnt_next = cnt_reg + PER_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_d_reg <= 1'b0;
         // Saturated, so the first edge after reset claims no rate
         cnt_reg   <= PER_W'(P8K_MAX + 1);
         rate_reg  <= RATE_8K;
         valid_reg <= 1'b0;
      end else begin
         ref_d_reg <= ref_d_next;
         cnt_reg   <= cnt_next;
         rate_reg  <= rate_next;
         valid_reg <= valid_next;
      end
   end

   assign rate       = rate_reg;
   assign rate_valid = valid_reg;

endmodule : dms_rate_detect

/* dms_ref_source.sv */
// Reference clock source model for the loop's reference input
`timescale 1ns/1ps
module dms_ref_source (
   input  wire logic        clk,    // Master clock
   input  wire logic        run,    // Source present
   input  wire logic [13:0] period, // Period in clk cycles
   output logic             ref_out // Reference clock
);
   logic [13:0] cnt_reg;
   logic [13:0] cnt_next;
   logic        ref_next;
   always_comb begin
      cnt_next = (cnt_reg + 14'h1 >= period) ? 14'h0 : cnt_reg + 14'h1;
      ref_next = run && (cnt_reg < (period >> 1));
      if (!run) begin
         cnt_next = 14'h0; // Pin is pulled down while the source is gone
      end
   end
   always_ff @(posedge clk) begin
      cnt_reg <= cnt_next;
      ref_out <= ref_next;
   end
endmodule : dms_ref_source
